// ==== ppr_pkg.sv ====
// ppr_pkg: constants and carriers for the peripheral pin redirection block
// assumes one system clock and an 8-bit cpu memory port with 20-bit addresses
package ppr_pkg;
    localparam int NPORT = 10;
    // pad group index: 0,1,2,3,4,6,7,8,12,13
    localparam logic [3:0] PI0  = 4'h0;
    localparam logic [3:0] PI1  = 4'h1;
    localparam logic [3:0] PI2  = 4'h2;
    localparam logic [3:0] PI3  = 4'h3;
    localparam logic [3:0] PI6  = 4'h5;
    localparam logic [3:0] PI7  = 4'h6;
    localparam logic [3:0] PI8  = 4'h7;
    localparam logic [3:0] PI12 = 4'h8;
    localparam logic [3:0] PI13 = 4'h9;
    // register addresses
    localparam logic [19:0] REDIR_ADDR = 20'hF_0077;
    localparam logic [19:0] CFG_BASE   = 20'hF_0300;
    localparam int          NCFG       = 15;
    localparam logic [7:0]  REDIR_RST  = 8'h00;
    localparam logic [7:0]  REDIR_MASK = 8'h1F;
    // redirect select bit positions
    localparam int RB_TMR  = 0;
    localparam int RB_S0   = 1;
    localparam int RB_S1   = 2;
    localparam int RB_MISC = 3;
    localparam int RB_IRQ  = 4;
    // configuration register indices (address = CFG_BASE + index)
    localparam logic [3:0] CI_DIR0 = 4'h0;
    localparam logic [3:0] CI_DIR1 = 4'h1;
    localparam logic [3:0] CI_DIR2 = 4'h2;
    localparam logic [3:0] CI_DIR3 = 4'h3;
    localparam logic [3:0] CI_PU0  = 4'h4;
    localparam logic [3:0] CI_PU1  = 4'h5;
    localparam logic [3:0] CI_PU3  = 4'h6;
    localparam logic [3:0] CI_LCD1 = 4'h7;
    localparam logic [3:0] CI_LCD3 = 4'h8;
    localparam logic [3:0] CI_EN1  = 4'h9;
    localparam logic [3:0] CI_EN3  = 4'hA;
    localparam logic [3:0] CI_ANA  = 4'hB;
    localparam logic [3:0] CI_TTL  = 4'hC;
    localparam logic [3:0] CI_OD0  = 4'hD;
    localparam logic [3:0] CI_OD1  = 4'hE;
    // reset values and writable bits, index 14 first
    localparam logic [NCFG-1:0][7:0] CFG_RST = {8'h00, 8'h00, 8'h00, 8'h3F,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
    localparam logic [NCFG-1:0][7:0] CFG_MASK = {8'hE0, 8'hFE, 8'h3F, 8'h3F,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
    // pin locations {group index, bit}, element 0 last
    localparam logic [7:0][7:0] IRQ_DEF = {8'h42, 8'h44, 8'h02, 8'h04, 8'h05, 8'h07, 8'h85, 8'h97};
    localparam logic [7:0][7:0] IRQ_ALT = {8'h67, 8'h66, 8'h65, 8'h64, 8'h63, 8'h62, 8'h61, 8'h60};
    localparam logic [7:0][7:0] TMR_DEF = {8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h41, 8'h43};
    localparam logic [7:0][7:0] TMR_ALT = {8'h30, 8'h31, 8'h85, 8'h86, 8'h87, 8'h52, 8'h51, 8'h50};
    // misc group: buzzer0, buzzer1, comparator0, comparator1, rtc pulse
    localparam logic [4:0][7:0] MSC_DEF = {8'h90, 8'h01, 8'h00, 8'h41, 8'h43};
    localparam logic [4:0][7:0] MSC_ALT = {8'h52, 8'h04, 8'h03, 8'h32, 8'h33};
    // serial groups: transmit/out, receive/data, clock
    localparam logic [2:0][7:0] S1_DEF = {8'h02, 8'h03, 8'h04};
    localparam logic [2:0][7:0] S1_ALT = {8'h70, 8'h71, 8'h72};
    localparam logic [2:0][7:0] S0_DEF = {8'h05, 8'h06, 8'h07};
    localparam logic [2:0][7:0] S0_ALT = {8'h15, 8'h16, 8'h17};

    typedef logic [NPORT-1:0][7:0] ppr_pad_t;

    // peripheral drive towards the pins
    typedef struct packed {
        logic [7:0] tmr_out;
        logic [7:0] tmr_oe;
        logic [4:0] msc_out;
        logic [4:0] msc_en;
        logic       s1_txd;
        logic       s1_txd_en;
        logic       s1_scl;
        logic       s1_sda;
        logic       s1_i2c_en;
        logic       s0_so;
        logic       s0_so_en;
        logic       s0_sck;
        logic       s0_sck_oe;
        logic       s0_sda;
        logic       s0_i2c_en;
    } ppr_fn_out_s;

    // pin levels towards the peripherals
    typedef struct packed {
        logic [7:0] irq;
        logic [7:0] tmr_in;
        logic       s1_rx;
        logic       s1_scl_in;
        logic       s0_si;
        logic       s0_sck_in;
    } ppr_fn_in_s;
endpackage

// ==== ppr_redirect.sv ====
// ppr_redirect: peripheral pin redirection and pin function selection
// assumes pad inputs are asynchronous; peripheral and gpio signals share mclk_i
//
// Functional notes
// - reset clears redirect select register
// - redirect register 8-bit read and write
// - each select bit moves whole group
// - bit 4 moves external interrupts to P70-P77
// - bit 3 moves buzzer, comparator, rtc pulse
// - bit 2 moves serial unit 1 pins
// - bit 1 moves serial 0 channel 0
// - bit 0 moves timer channel pins
// - redirected interrupt 0 off on battery
// - default interrupt 0 pin works on battery
// - port 0 resets to digital input
// - ports 1, 3 reset isolated
// - port 2 resets to analog input
// - per-pin digital or lcd selection
// - per-pin port 2 digital or analog
// - per-pin pull-up on input pins
// - ttl input threshold on six pins
// - open-drain option on ten outputs
module ppr_redirect
    import ppr_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // cpu memory port
    input  wire logic [19:0] mem_addr_i,
    input  wire logic [7:0]  mem_wdata_i,
    input  wire logic        mem_wr_i,
    input  wire logic        mem_rd_i,
    output logic      [7:0]  mem_rdata_o,
    // supply state
    input  wire logic        vbat_i,
    // gpio data and peripherals
    input  wire ppr_pad_t    gpio_dout_i,
    output ppr_pad_t         gpio_din_o,
    input  wire ppr_fn_out_s fn_out_i,
    output ppr_fn_in_s       fn_in_o,
    // pads
    input  wire ppr_pad_t    pad_in_i,
    output ppr_pad_t         pad_do_o,
    output ppr_pad_t         pad_oe_o,
    output ppr_pad_t         pull_en_o,
    output ppr_pad_t         ttl_en_o,
    output ppr_pad_t         lcd_en_o,
    output logic      [5:0]  analog_en_o
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]            redir;
        logic [NCFG-1:0][7:0]  cfg;
        ppr_pad_t              s1;
        ppr_pad_t              s2;
        logic [1:0]            vb;
        ppr_pad_t              pdo;
        ppr_pad_t              poe;
        ppr_pad_t              pull;
        ppr_pad_t              ttl;
        ppr_pad_t              lcd;
        ppr_pad_t              din;
        logic [5:0]            ana;
        ppr_fn_in_s            fin;
        logic [7:0]            rdata;
        logic                  wseen;
    } ppr_state_s;

    localparam ppr_state_s ST_RST = '{redir: REDIR_RST, cfg: CFG_RST, ana: 6'h3F, default: '0};

    ppr_state_s  st_r;
    ppr_state_s  st_nxt;
    logic [19:0] cfg_off;
    logic        cfg_hit;

    // set or read one pad bit at a location code
    function automatic ppr_pad_t setb(ppr_pad_t v, logic [7:0] l, logic b);
        ppr_pad_t r;
        r = v;
        r[l[7:4]][l[2:0]] = b;
        return r;
    endfunction

    function automatic logic getb(ppr_pad_t v, logic [7:0] l);
        return v[l[7:4]][l[2:0]];
    endfunction

    // configuration window decode
    assign cfg_off = mem_addr_i - CFG_BASE;
    assign cfg_hit = (mem_addr_i >= CFG_BASE) && (cfg_off < 20'(NCFG));

    ////////////////////////////////////////////////////////////////////////////
    // next state: registers, synchronisers, pin multiplexing
    always_comb begin
        ppr_pad_t   fdo;
        ppr_pad_t   foe;
        ppr_pad_t   fod;
        ppr_pad_t   dig;
        ppr_pad_t   dir;
        ppr_pad_t   din;
        logic [7:0] r;
        logic [7:0] l;
        logic [7:0] t;
        fdo = gpio_dout_i;
        foe = '0;
        fod = '0;
        dig = '1;
        dir = '0;
        din = '0;
        l = '0;
        st_nxt = st_r;
        r = st_r.redir;
        t = st_r.cfg[CI_TTL];
        // register writes
        if (mem_wr_i && (mem_addr_i == REDIR_ADDR)) begin
            st_nxt.redir = mem_wdata_i & REDIR_MASK;
            st_nxt.wseen = 1'b1;
        end else if (mem_wr_i && cfg_hit) begin
            st_nxt.cfg[cfg_off[3:0]] = mem_wdata_i & CFG_MASK[cfg_off[3:0]];
        end
        // register reads, unmapped reads zero
        if (mem_rd_i) begin
            if (mem_addr_i == REDIR_ADDR) begin
                st_nxt.rdata = st_r.redir;
            end else if (cfg_hit) begin
                st_nxt.rdata = st_r.cfg[cfg_off[3:0]];
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
        // two-stage synchronisers
        st_nxt.s1 = pad_in_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.vb = {st_r.vb[0], vbat_i};
        // direction, isolation, lcd and analog gating
        dir[PI0] = st_r.cfg[CI_DIR0];
        dir[PI1] = st_r.cfg[CI_DIR1];
        dir[PI2] = st_r.cfg[CI_DIR2];
        dir[PI3] = st_r.cfg[CI_DIR3];
        dig[PI1] = st_r.cfg[CI_EN1] & ~st_r.cfg[CI_LCD1];
        dig[PI3] = st_r.cfg[CI_EN3] & ~st_r.cfg[CI_LCD3];
        dig[PI2] = {2'b00, ~st_r.cfg[CI_ANA][5:0]}; // bits 7:6 have no pins
        st_nxt.lcd = '0;
        st_nxt.lcd[PI1] = st_r.cfg[CI_EN1] & st_r.cfg[CI_LCD1] & dir[PI1];
        st_nxt.lcd[PI3] = st_r.cfg[CI_EN3] & st_r.cfg[CI_LCD3] & dir[PI3];
        st_nxt.ana = st_r.cfg[CI_ANA][5:0];
        din = st_r.s2 & dig;
        st_nxt.din = din;
        // gpio drive on ports 0-3
        for (int p = 0; p < 4; p++) begin
            foe[p] = ~dir[p];
        end
        fod[PI0] = st_r.cfg[CI_OD0];
        fod[PI1] = st_r.cfg[CI_OD1];
        // misc outputs: buzzers, comparators, rtc pulse
        for (int i = 0; i < 5; i++) begin
            l = r[RB_MISC] ? MSC_ALT[i] : MSC_DEF[i];
            if (fn_out_i.msc_en[i]) begin
                fdo = setb(fdo, l, fn_out_i.msc_out[i]);
                foe = setb(foe, l, 1'b1);
            end
        end
        // timer channels, both directions
        for (int i = 0; i < 8; i++) begin
            l = r[RB_TMR] ? TMR_ALT[i] : TMR_DEF[i];
            if (fn_out_i.tmr_oe[i]) begin
                fdo = setb(fdo, l, fn_out_i.tmr_out[i]);
                foe = setb(foe, l, 1'b1);
            end
            st_nxt.fin.tmr_in[i] = getb(din, l);
        end
        // external interrupt inputs
        for (int i = 0; i < 8; i++) begin
            l = r[RB_IRQ] ? IRQ_ALT[i] : IRQ_DEF[i];
            st_nxt.fin.irq[i] = getb(din, l);
        end
        if (r[RB_IRQ] && st_r.vb[1]) begin
            st_nxt.fin.irq[0] = 1'b0;
        end
        // serial unit 1
        l = r[RB_S1] ? S1_ALT[0] : S1_DEF[0];
        if (fn_out_i.s1_txd_en) begin
            fdo = setb(fdo, l, fn_out_i.s1_txd);
            foe = setb(foe, l, 1'b1);
        end
        l = r[RB_S1] ? S1_ALT[1] : S1_DEF[1];
        st_nxt.fin.s1_rx = getb(din, l);
        if (fn_out_i.s1_i2c_en) begin
            fdo = setb(fdo, l, fn_out_i.s1_sda);
            foe = setb(foe, l, 1'b1);
            fod = setb(fod, l, 1'b1);
        end
        l = r[RB_S1] ? S1_ALT[2] : S1_DEF[2];
        st_nxt.fin.s1_scl_in = getb(din, l);
        if (fn_out_i.s1_i2c_en) begin
            fdo = setb(fdo, l, fn_out_i.s1_scl);
            foe = setb(foe, l, 1'b1);
            fod = setb(fod, l, 1'b1);
        end
        // serial unit 0 channel 0
        l = r[RB_S0] ? S0_ALT[0] : S0_DEF[0];
        if (fn_out_i.s0_so_en) begin
            fdo = setb(fdo, l, fn_out_i.s0_so);
            foe = setb(foe, l, 1'b1);
        end
        l = r[RB_S0] ? S0_ALT[1] : S0_DEF[1];
        st_nxt.fin.s0_si = getb(din, l);
        if (fn_out_i.s0_i2c_en) begin
            fdo = setb(fdo, l, fn_out_i.s0_sda);
            foe = setb(foe, l, 1'b1);
            fod = setb(fod, l, 1'b1);
        end
        l = r[RB_S0] ? S0_ALT[2] : S0_DEF[2];
        st_nxt.fin.s0_sck_in = getb(din, l);
        if (fn_out_i.s0_sck_oe) begin
            fdo = setb(fdo, l, fn_out_i.s0_sck);
            foe = setb(foe, l, 1'b1);
            if (fn_out_i.s0_i2c_en) begin
                fod = setb(fod, l, 1'b1);
            end
        end
        // open-drain releases a high level; isolated or analog pins never drive
        st_nxt.pdo = fdo;
        st_nxt.poe = foe & dig & ~(fod & fdo);
        // pull-ups on digital input pins of ports 0, 1, 3
        st_nxt.pull = '0;
        st_nxt.pull[PI0] = st_r.cfg[CI_PU0] & dir[PI0];
        st_nxt.pull[PI1] = st_r.cfg[CI_PU1] & dir[PI1] & dig[PI1];
        st_nxt.pull[PI3] = st_r.cfg[CI_PU3] & dir[PI3] & dig[PI3];
        // ttl threshold on P00, P03, P05, P06, P15, P16
        st_nxt.ttl = '0;
        st_nxt.ttl[PI0] = {1'b0, t[3], t[2], 1'b0, t[1], 2'b00, t[0]};
        st_nxt.ttl[PI1] = {1'b0, t[5], t[4], 5'b0_0000};
    end

    // state register
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign mem_rdata_o = st_r.rdata;
    assign gpio_din_o  = st_r.din;
    assign fn_in_o     = st_r.fin;
    assign pad_do_o    = st_r.pdo;
    assign pad_oe_o    = st_r.poe;
    assign pull_en_o   = st_r.pull;
    assign ttl_en_o    = st_r.ttl;
    assign lcd_en_o    = st_r.lcd;
    assign analog_en_o = st_r.ana;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    chk_redir_reset_zero: assert property (!st_r.wseen |-> st_r.redir == REDIR_RST)
        else $error("redirect select not zero before first write");
    chk_redir_read_back: assert property (
        (mem_wr_i && mem_addr_i == REDIR_ADDR) ##1 (mem_rd_i && !mem_wr_i && mem_addr_i == REDIR_ADDR)
        |=> mem_rdata_o == ($past(mem_wdata_i, 2) & REDIR_MASK))
        else $error("redirect select read back wrong");
    chk_redir_upper_zero: assert property (
        mem_rd_i && mem_addr_i == REDIR_ADDR |=> mem_rdata_o[7:5] == 3'b000)
        else $error("redirect select upper bits not zero");
    chk_irq_route: assert property (
        1'b1 |=> fn_in_o.irq[3] == ($past(st_r.redir[RB_IRQ]) ? $past(st_r.s2[PI7][3]) : $past(st_r.s2[PI0][5])))
        else $error("interrupt 3 taken from wrong pin");
    chk_irq0_battery: assert property (st_r.redir[RB_IRQ] && st_r.vb[1] |=> !fn_in_o.irq[0])
        else $error("redirected interrupt 0 live on battery");
    chk_irq0_default: assert property (!st_r.redir[RB_IRQ] |=> fn_in_o.irq[0] == $past(st_r.s2[PI13][7]))
        else $error("default interrupt 0 pin not followed");
    chk_rtc_alt_pin: assert property (
        st_r.redir[RB_MISC] && fn_out_i.msc_en[4] && !fn_out_i.tmr_oe[2]
        |=> pad_oe_o[PI6][2] && pad_do_o[PI6][2] == $past(fn_out_i.msc_out[4]))
        else $error("rtc pulse not on alternate pin");
    chk_s1_tx_alt: assert property (
        st_r.redir[RB_S1] && fn_out_i.s1_txd_en
        |=> pad_oe_o[PI8][2] && pad_do_o[PI8][2] == $past(fn_out_i.s1_txd))
        else $error("serial 1 transmit not on alternate pin");
    chk_s0_clk_def: assert property (
        !st_r.redir[RB_S0] && fn_out_i.s0_sck_oe && !fn_out_i.s0_i2c_en
        |=> pad_do_o[PI0][5] == $past(fn_out_i.s0_sck))
        else $error("serial 0 clock not on default pin");
    chk_tmr_alt_pin: assert property (
        st_r.redir[RB_TMR] && fn_out_i.tmr_oe[3]
        |=> pad_oe_o[PI12][7] && pad_do_o[PI12][7] == $past(fn_out_i.tmr_out[3]))
        else $error("timer 3 not on alternate pin");
    chk_port3_isolated: assert property (
        st_r.cfg[CI_EN3] == 8'h00
        |=> pad_oe_o[PI3] == 8'h00 && lcd_en_o[PI3] == 8'h00 && gpio_din_o[PI3] == 8'h00)
        else $error("isolated port 3 still active");
    chk_port2_analog: assert property (st_r.cfg[CI_ANA][0] |=> analog_en_o[0] && !gpio_din_o[PI2][0])
        else $error("analog pin still digital");
    chk_lcd_select: assert property (
        st_r.cfg[CI_EN1][0] && st_r.cfg[CI_LCD1][0] && st_r.cfg[CI_DIR1][0]
        |=> lcd_en_o[PI1][0] && !pad_oe_o[PI1][0])
        else $error("lcd pin not selected");
    chk_open_drain_high: assert property (
        st_r.cfg[CI_OD0][1] && gpio_dout_i[PI0][1] && !fn_out_i.msc_en[3]
        |=> !pad_oe_o[PI0][1])
        else $error("open-drain pin drives high");
    chk_pull_input: assert property (st_r.cfg[CI_PU0][2] && st_r.cfg[CI_DIR0][2] |=> pull_en_o[PI0][2])
        else $error("pull-up missing on input pin");
    chk_ttl_select: assert property (st_r.cfg[CI_TTL][4] |=> ttl_en_o[PI1][5])
        else $error("ttl threshold not applied");

    cov_redir_write: cover property (mem_wr_i && mem_addr_i == REDIR_ADDR && mem_wdata_i[RB_IRQ]);
    cov_irq0_battery: cover property (st_r.redir[RB_IRQ] && st_r.vb[1]);
    cov_s0_moved: cover property (st_r.redir[RB_S0] && fn_out_i.s0_so_en);
    cov_lcd_used: cover property (lcd_en_o[PI3] != 8'h00);

endmodule // ppr_redirect

// ==== ppr_redirect_tb.sv ====
// ppr_redirect_tb: self-checking bench for the peripheral pin redirection block
// assumes ppr_pkg and ppr_redirect are compiled first; assertions live in the design
module ppr_redirect_tb
    import ppr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int G4 = 4; // pad group of port 4

    logic        mclk_i      = 1'b0;
    logic        rst_b_i     = 1'b0;
    logic [19:0] mem_addr_i  = '0;
    logic [7:0]  mem_wdata_i = '0;
    logic        mem_wr_i    = 1'b0;
    logic        mem_rd_i    = 1'b0;
    logic [7:0]  mem_rdata_o;
    logic        vbat_i      = 1'b0;
    ppr_pad_t    gpio_dout_i = '0;
    ppr_pad_t    gpio_din_o;
    ppr_fn_out_s fn_out_i    = '0;
    ppr_fn_in_s  fn_in_o;
    ppr_pad_t    pad_in_i    = '1;
    ppr_pad_t    pad_do_o;
    ppr_pad_t    pad_oe_o;
    ppr_pad_t    pull_en_o;
    ppr_pad_t    ttl_en_o;
    ppr_pad_t    lcd_en_o;
    logic [5:0]  analog_en_o;
    int          err_total   = 0;
    int          comparisons = 0;

    ppr_redirect uut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
        .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i), .mem_rdata_o(mem_rdata_o), .vbat_i(vbat_i),
        .gpio_dout_i(gpio_dout_i), .gpio_din_o(gpio_din_o), .fn_out_i(fn_out_i), .fn_in_o(fn_in_o),
        .pad_in_i(pad_in_i), .pad_do_o(pad_do_o), .pad_oe_o(pad_oe_o), .pull_en_o(pull_en_o),
        .ttl_en_o(ttl_en_o), .lcd_en_o(lcd_en_o), .analog_en_o(analog_en_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end

    // the tests need well under 2000 cycles; give ten times that
    initial begin
        #2_000_000;
        err_total++;
        $display("ERROR watchdog expired");
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tasks
    function automatic logic [19:0] ca(input logic [3:0] idx);
        return CFG_BASE + {16'h0000, idx};
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one-cycle write strobe, taken at the edge that sees it high
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        mem_addr_i  <= a;
        mem_wdata_i <= d;
        mem_wr_i    <= 1'b1;
        @(posedge mclk_i);
        mem_wr_i    <= 1'b0;
    endtask

    // one-cycle read strobe, data checked one cycle after the taking edge
    task automatic rd(input string nm, input logic [19:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        mem_addr_i <= a;
        mem_rd_i   <= 1'b1;
        @(posedge mclk_i);
        mem_rd_i   <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk(nm, e, mem_rdata_o);
    endtask

    // write then read the same place on the very next edge; the read sees the new value
    task automatic wr_rd(input string nm, input logic [19:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge mclk_i);
        mem_addr_i  <= a;
        mem_wdata_i <= d;
        mem_wr_i    <= 1'b1;
        @(posedge mclk_i);
        mem_wr_i    <= 1'b0;
        mem_rd_i    <= 1'b1;
        @(posedge mclk_i);
        mem_rd_i    <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk(nm, e, mem_rdata_o);
    endtask

    // software order: functions off while the routing changes, then back on
    task automatic redirect(input logic [7:0] v);
        ppr_fn_out_s keep;
        keep = fn_out_i;
        fn_out_i <= '0;
        wr(REDIR_ADDR, v);
        fn_out_i <= keep;
    endtask

    // lets synchronisers and output registers catch up
    task automatic settle();
        repeat (5) @(posedge mclk_i);
        #1;
    endtask

    task automatic end_of_test();
        $display("counts: comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        settle();
        // reset state of ports and register
        chk("port0 din", 8'hFF, gpio_din_o[PI0]);
        chk("port1 din", 8'h00, gpio_din_o[PI1]);
        chk("port3 din", 8'h00, gpio_din_o[PI3]);
        chk("port1 oe", 8'h00, pad_oe_o[PI1]);
        chk("port3 lcd", 8'h00, lcd_en_o[PI3]);
        chk("analog en", 8'h3F, {2'b00, analog_en_o});
        chk("port2 din", 8'h00, gpio_din_o[PI2] & 8'h3F);
        rd("redirect reset", REDIR_ADDR, 8'h00);
        $display("test reset done");

        // register access, reserved bits, unmapped place
        wr_rd("redirect readback", REDIR_ADDR, 8'hFF, 8'h1F);
        wr(REDIR_ADDR, 8'h00);
        rd("redirect cleared", REDIR_ADDR, 8'h00);
        rd("unmapped", 20'hF_0078, 8'h00);
        $display("test register done");

        // per-pin options while port 0 is input
        wr(ca(CI_PU0), 8'h0F);
        wr(ca(CI_TTL), 8'h3F);
        wr(ca(CI_ANA), 8'h05);
        wr(ca(CI_EN1), 8'h01);
        wr(ca(CI_LCD1), 8'h01);
        settle();
        chk("pull port0", 8'h0F, pull_en_o[PI0]);
        chk("ttl port0", 8'h69, ttl_en_o[PI0]);
        chk("analog sel", 8'h05, {2'b00, analog_en_o});
        chk("port2 digital din", 8'h3A, gpio_din_o[PI2] & 8'h3F);
        rd("analog readback", ca(CI_ANA), 8'h05);
        chk("lcd p10 on", 8'h01, lcd_en_o[PI1]);
        wr(ca(CI_LCD1), 8'h00);
        settle();
        chk("lcd p10 off", 8'h00, lcd_en_o[PI1]);
        $display("test pin options done");

        // misc outputs: port 0 and 3 as digital outputs driving low
        wr(ca(CI_DIR0), 8'h00);
        wr(ca(CI_DIR3), 8'h00);
        wr(ca(CI_EN3), 8'hFF);
        fn_out_i.msc_en  <= 5'h1F;
        fn_out_i.msc_out <= 5'h1F;
        settle();
        chk("misc def do0", 8'h03, pad_do_o[PI0]);
        chk("misc def oe4", 8'h0A, pad_oe_o[G4]);
        chk("misc def oe13", 8'h01, pad_oe_o[PI13]);
        redirect(8'h08);
        settle();
        chk("misc alt do0", 8'h18, pad_do_o[PI0]);
        chk("misc alt do3", 8'h0C, pad_do_o[PI3]);
        chk("misc alt oe4", 8'h00, pad_oe_o[G4]);
        chk("misc alt oe13", 8'h00, pad_oe_o[PI13]);
        chk("misc alt oe6", 8'h04, pad_oe_o[PI6]);
        fn_out_i.msc_en  <= 5'h00;
        wr(REDIR_ADDR, 8'h00);
        $display("test misc group done");

        // timer channels 0, 1 and 3 as outputs, channels 0 and 1 as inputs
        fn_out_i.tmr_oe  <= 8'h0B;
        fn_out_i.tmr_out <= 8'h0B;
        pad_in_i <= '0;
        settle();
        pad_in_i[G4]  <= 8'h08;
        pad_in_i[PI6] <= 8'h02;
        settle();
        chk("tmr def oe4", 8'h0A, pad_oe_o[G4]);
        chk("tmr def oe6", 8'h00, pad_oe_o[PI6]);
        chk("tmr def in", 8'h01, {6'h00, fn_in_o.tmr_in[1:0]});
        redirect(8'h01);
        settle();
        chk("tmr alt oe4", 8'h00, pad_oe_o[G4]);
        chk("tmr alt oe6", 8'h03, pad_oe_o[PI6]);
        chk("tmr alt oe12", 8'h80, pad_oe_o[PI12]);
        chk("tmr alt in", 8'h02, {6'h00, fn_in_o.tmr_in[1:0]});
        fn_out_i.tmr_oe <= 8'h00;
        wr(REDIR_ADDR, 8'h00);
        $display("test timer group done");

        // external interrupts and the battery supply
        pad_in_i <= '0;
        settle();
        pad_in_i[PI7] <= 8'hFF;
        settle();
        chk("irq def", 8'h00, fn_in_o.irq);
        wr(REDIR_ADDR, 8'h10);
        settle();
        chk("irq alt", 8'hFF, fn_in_o.irq);
        vbat_i <= 1'b1;
        settle();
        chk("irq alt vbat", 8'hFE, fn_in_o.irq);
        wr(REDIR_ADDR, 8'h00);
        pad_in_i[PI13] <= 8'h80;
        settle();
        chk("irq def vbat", 8'h01, fn_in_o.irq);
        vbat_i <= 1'b0;
        $display("test interrupt group done");

        // both serial units, moved one group at a time
        wr(ca(CI_EN1), 8'hFF);
        wr(ca(CI_DIR1), 8'h00);
        pad_in_i <= '0;
        fn_out_i.s1_txd_en <= 1'b1;
        fn_out_i.s1_txd    <= 1'b1;
        fn_out_i.s0_so_en  <= 1'b1;
        fn_out_i.s0_so     <= 1'b1;
        fn_out_i.s0_sck_oe <= 1'b1;
        fn_out_i.s0_sck    <= 1'b1;
        settle();
        pad_in_i[PI8] <= 8'h02;
        pad_in_i[PI1] <= 8'h40;
        settle();
        chk("ser def do0", 8'hB0, pad_do_o[PI0]);
        chk("ser def do1", 8'h00, pad_do_o[PI1]);
        chk("ser def si", 8'h00, {7'h00, fn_in_o.s0_si});
        redirect(8'h02);
        settle();
        chk("s0 alt do0", 8'h10, pad_do_o[PI0]);
        chk("s0 alt do1", 8'hA0, pad_do_o[PI1]);
        chk("s0 alt si", 8'h01, {7'h00, fn_in_o.s0_si});
        chk("s1 still def rx", 8'h00, {7'h00, fn_in_o.s1_rx});
        redirect(8'h06);
        settle();
        chk("s1 alt do0", 8'h00, pad_do_o[PI0]);
        chk("s1 alt oe8", 8'h04, pad_oe_o[PI8]);
        chk("s1 alt rx", 8'h01, {7'h00, fn_in_o.s1_rx});
        fn_out_i <= '0;
        wr(REDIR_ADDR, 8'h00);
        $display("test serial groups done");

        // open-drain drive on ports 0 and 1 with data high
        gpio_dout_i[PI0] <= 8'hFF;
        gpio_dout_i[PI1] <= 8'hFF;
        wr(ca(CI_OD0), 8'hFE);
        wr(ca(CI_OD1), 8'hE0);
        settle();
        chk("od oe0", 8'h01, pad_oe_o[PI0]);
        chk("od oe1", 8'h1F, pad_oe_o[PI1]);
        $display("test open drain done");

        end_of_test();
    end
endmodule // ppr_redirect_tb
